//--- agcc_host.sv
`timescale 1ns/1ns
module agcc_host
  import agcc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic [31:0] cfg_rdata,
  input  wire logic        cfg_rack,
  output logic      [7:0]  cfg_addr,
  output logic      [3:0]  cfg_be,
  output logic             cfg_wr,
  output logic             cfg_rd,
  output logic      [31:0] cfg_wdata
);
  logic       target_en = 1'b0;
  logic [2:0] target_rate = 3'h0;
  initial
  begin
    cfg_addr = 8'h00;
    cfg_be = 4'h0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = 32'h0000_0000;
  end
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge ref_clk);
    cfg_addr = a;
    cfg_be = be;
    cfg_wdata = d;
    cfg_wr = 1'b1;
    @(negedge ref_clk);
    cfg_wr = 1'b0;
    cfg_wdata = ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic ack);
    @(negedge ref_clk);
    cfg_addr = a;
    cfg_rd = 1'b1;
    @(negedge ref_clk);
    cfg_rd = 1'b0;
    d = cfg_rdata;
    ack = cfg_rack;
  endtask
  // The target is set up fully before this device is allowed to master.
  task automatic start_target(input logic [7:0] depth);
    target_rate = AGCC_RATE_RESET;
    target_en = 1'b1;
    wr(AGCC_OFF_COMMAND, 4'hF, {depth, 14'h0000, 1'b0, 1'b1, 5'h00, 3'h1});
  endtask
endmodule // agcc_host

//--- agcc_pkg.sv
// How it works
// - The capability pointer at config offset 0x34 reads 0x44 when the AGP strap is high, else 0.
// - The capability header returns the type code 0x02 in bits 7:0.
// - The header reports revision major 0x1 in bits 23:20 and minor 0x0 in bits 19:16.
// - The next-entry pointer in header bits 15:8 reads 0x00, ending the chain.
// - Status bits 31:24 read 0x04, the most requests the device keeps outstanding.
// - Status bit 9 always reads 0 because sideband addressing is not offered.
// - Status bits 1:0 read 01, single-rate 66 MHz transfers only.
// - Command bit 9, the sideband enable, is read-only and always reads 0.
// - Command bit 8 is RW, resets to 0, and while 0 the device initiates no bus operation.
// - Command bits 2:0 are RW, reset to 0x01, and software programs 0x01 for single rate.
package agcc_pkg;

  localparam logic [7:0]  AGCC_OFF_CAP_LIST = 8'h34;
  localparam logic [7:0]  AGCC_OFF_HEADER  = 8'h44;
  localparam logic [7:0]  AGCC_OFF_STATUS  = 8'h48;
  localparam logic [7:0]  AGCC_OFF_COMMAND = 8'h4C;

  // Header fields.
  localparam logic [7:0]  AGCC_CAP_TYPE_CODE  = 8'h02;
  localparam logic [3:0]  AGCC_REV_MAJOR      = 4'h1;
  localparam logic [3:0]  AGCC_REV_MINOR      = 4'h0;
  localparam logic [7:0]  AGCC_NEXT_ENTRY_PTR = 8'h00;
  localparam logic [31:0] AGCC_HEADER_VALUE   = {8'h00, AGCC_REV_MAJOR, AGCC_REV_MINOR,
                                                 AGCC_NEXT_ENTRY_PTR, AGCC_CAP_TYPE_CODE};

  // Status fields.
  localparam logic [7:0]  AGCC_MAX_OUTSTANDING = 8'h04;
  localparam logic        AGCC_SIDEBAND_FLAG   = 1'b0;
  localparam logic [1:0]  AGCC_RATE_SUPPORT    = 2'h1;
  localparam logic [31:0] AGCC_STATUS_VALUE    = {AGCC_MAX_OUTSTANDING, 14'h0000,
                                                  AGCC_SIDEBAND_FLAG, 7'h00, AGCC_RATE_SUPPORT};

  // Command fields: positions and reset values; then the capability pointer value.
  localparam int          AGCC_CMD_DEPTH_LSB   = 24;
  localparam int          AGCC_CMD_SIDE_BIT    = 9;
  localparam int          AGCC_CMD_MEN_BIT     = 8;
  localparam int          AGCC_CMD_RATE_LSB    = 0;
  localparam logic [7:0]  AGCC_DEPTH_RESET     = 8'h00;
  localparam logic        AGCC_MEN_RESET       = 1'b0;
  localparam logic [2:0]  AGCC_RATE_RESET      = 3'h1;
  localparam logic [31:0] AGCC_CAP_LIST_VALUE  = 32'h0000_0044;

endpackage

//--- agcc_regs.sv
`timescale 1ns/1ns
module agcc_regs
  import agcc_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [7:0]  cfg_addr,
  input  wire logic [3:0]  cfg_be,
  input  wire logic        cfg_wr,
  input  wire logic        cfg_rd,
  input  wire logic [31:0] cfg_wdata,
  output logic      [31:0] cfg_rdata,
  output logic             cfg_rack,
  input  wire logic        agp_strap_pin,
  input  wire logic        init_req,
  output logic             init_req_ok,
  output logic             bus_master_enable_bit,
  output logic      [7:0]  programmed_request_depth,
  output logic      [2:0]  rate_select
);

  typedef struct packed {
    logic [7:0]  depth;
    logic        men;
    logic [2:0]  rate;
    logic [31:0] rdata;
    logic        rack;
    logic        gnt;
  } agcc_state_t;

  agcc_state_t s_q;
  agcc_state_t s_d;
  logic        strap_sync;
  logic [31:0] cmd_view;
  logic [31:0] read_mux;
  logic        wr_cmd;

  agcc_sync agcc_sync_i
  (
    .ref_clk  (ref_clk),
    .rst      (rst),
    .async_in (agp_strap_pin),
    .sync_out (strap_sync)
  );

  // Command word as software sees it; sideband enable and reserved bits are constant zero.
  always_comb
  begin
    cmd_view = 32'h0000_0000;
    cmd_view[AGCC_CMD_DEPTH_LSB +: 8] = s_q.depth;
    cmd_view[AGCC_CMD_SIDE_BIT]       = 1'b0;
    cmd_view[AGCC_CMD_MEN_BIT]        = s_q.men;
    cmd_view[AGCC_CMD_RATE_LSB +: 3]  = s_q.rate;
  end

  always_comb
  begin
    case (cfg_addr)
      AGCC_OFF_CAP_LIST: read_mux = strap_sync ? AGCC_CAP_LIST_VALUE : 32'h0000_0000;
      AGCC_OFF_HEADER:   read_mux = AGCC_HEADER_VALUE;
      AGCC_OFF_STATUS:   read_mux = AGCC_STATUS_VALUE;
      AGCC_OFF_COMMAND:  read_mux = cmd_view;
      default:           read_mux = 32'h0000_0000;
    endcase
  end

  // Header, status and pointer words hold no storage, so writes to them fall away.
  assign wr_cmd = cfg_wr && (cfg_addr == AGCC_OFF_COMMAND);

  always_comb
  begin
    s_d       = s_q;
    s_d.rack  = cfg_rd;
    s_d.rdata = cfg_rd ? read_mux : 32'h0000_0000;
    if (wr_cmd && cfg_be[3])
    begin
      s_d.depth = cfg_wdata[AGCC_CMD_DEPTH_LSB +: 8];
    end
    if (wr_cmd && cfg_be[1])
    begin
      s_d.men = cfg_wdata[AGCC_CMD_MEN_BIT];
    end
    if (wr_cmd && cfg_be[0])
    begin
      s_d.rate = cfg_wdata[AGCC_CMD_RATE_LSB +: 3];
    end
    // The engine's request is passed on only while mastering is enabled.
    s_d.gnt = init_req && s_q.men;
  end

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      s_q.depth <= AGCC_DEPTH_RESET;
      s_q.men   <= AGCC_MEN_RESET;
      s_q.rate  <= AGCC_RATE_RESET;
      s_q.rdata <= 32'h0000_0000;
      s_q.rack  <= 1'b0;
      s_q.gnt   <= 1'b0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  assign cfg_rdata                = s_q.rdata;
  assign cfg_rack                 = s_q.rack;
  assign init_req_ok              = s_q.gnt;
  assign bus_master_enable_bit    = s_q.men;
  assign programmed_request_depth = s_q.depth;
  assign rate_select              = s_q.rate;

  sequence rd_of(logic [7:0] a);
    cfg_rd && !cfg_wr && (cfg_addr == a);
  endsequence

  sequence cmd_write(int b);
    cfg_wr && (cfg_addr == AGCC_OFF_COMMAND) && cfg_be[b];
  endsequence

  capability_list_pointer_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_of(AGCC_OFF_CAP_LIST) |=> cfg_rack &&
      (cfg_rdata == ($past(strap_sync) ? 32'h0000_0044 : 32'h0000_0000)))
    else $error("capability pointer read wrong");

  header_value_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_of(AGCC_OFF_HEADER) |=> cfg_rack && cfg_rdata[7:0] == 8'h02)
    else $error("capability type code wrong");

  header_rev_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_of(AGCC_OFF_HEADER) |=> cfg_rdata[23:20] == 4'h1 && cfg_rdata[19:16] == 4'h0)
    else $error("revision fields wrong");

  next_entry_pointer_null_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_of(AGCC_OFF_HEADER) |=> cfg_rdata[15:8] == 8'h00 && cfg_rdata[31:24] == 8'h00)
    else $error("next entry pointer not null");

  status_depth_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_of(AGCC_OFF_STATUS) |=> cfg_rack && cfg_rdata[31:24] == 8'h04)
    else $error("outstanding request count wrong");

  status_sideband_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_of(AGCC_OFF_STATUS) |=> cfg_rdata[9] == 1'b0 && cfg_rdata[23:10] == 14'h0000)
    else $error("status sideband bit set");

  status_rate_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_of(AGCC_OFF_STATUS) |=> cfg_rdata[1:0] == 2'b01 && cfg_rdata[8:2] == 7'h00)
    else $error("supported rate wrong");

  depth_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_write(3) ##1 rd_of(AGCC_OFF_COMMAND) |=>
      cfg_rdata[31:24] == $past(cfg_wdata[31:24], 2))
    else $error("request depth not stored");

  cmd_sideband_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_of(AGCC_OFF_COMMAND) |=> cfg_rdata[9] == 1'b0 && cfg_rdata[23:10] == 14'h0000
      && cfg_rdata[7:3] == 5'h00)
    else $error("command read-only bits not zero");

  master_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    init_req_ok |-> $past(bus_master_enable_bit) && $past(init_req))
    else $error("request passed while mastering disabled");

  master_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
    (init_req && bus_master_enable_bit) |=> init_req_ok)
    else $error("enabled request not passed");

  master_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_write(1) |=> bus_master_enable_bit == $past(cfg_wdata[8]))
    else $error("master enable not written");

  rate_write_a: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_write(0) |=> rate_select == $past(cfg_wdata[2:0]))
    else $error("rate select not written");

  rate_reset_a: assert property (@(posedge ref_clk)
    rst |=> rst || (rate_select == 3'h1 && !bus_master_enable_bit))
    else $error("command reset values wrong");

  ro_write_ignored_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg_wr && cfg_addr != AGCC_OFF_COMMAND) |=> $stable(cmd_view))
    else $error("write outside command word changed state");

  // Unmapped reads still answer, so software probing past the list never hangs.
  unmapped_read_a: assert property (@(posedge ref_clk) disable iff (rst)
    (cfg_rd && cfg_addr != AGCC_OFF_CAP_LIST && cfg_addr != AGCC_OFF_HEADER &&
     cfg_addr != AGCC_OFF_STATUS && cfg_addr != AGCC_OFF_COMMAND) |=>
      cfg_rack && cfg_rdata == 32'h0000_0000)
    else $error("unmapped read not zero");

  idle_rdata_a: assert property (@(posedge ref_clk) disable iff (rst)
    !cfg_rd |=> !cfg_rack && cfg_rdata == 32'h0000_0000)
    else $error("read data shown without a read");

  men_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(cfg_wr && cfg_addr == AGCC_OFF_COMMAND && cfg_be[1]) |=> $stable(bus_master_enable_bit))
    else $error("master enable changed without a write");

  depth_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(cfg_wr && cfg_addr == AGCC_OFF_COMMAND && cfg_be[3]) |=>
      $stable(programmed_request_depth))
    else $error("request depth changed without a write");

  rate_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
    !(cfg_wr && cfg_addr == AGCC_OFF_COMMAND && cfg_be[0]) |=> $stable(rate_select))
    else $error("rate select changed without a write");

  no_grant_off_a: assert property (@(posedge ref_clk) disable iff (rst)
    !bus_master_enable_bit |=> !init_req_ok)
    else $error("request passed with mastering off");

  depth_reset_a: assert property (@(posedge ref_clk)
    rst |=> rst || programmed_request_depth == 8'h00)
    else $error("request depth reset value wrong");

  // A read in the same cycle as a write returns the old command value.
  cmd_live_a: assert property (@(posedge ref_clk) disable iff (rst)
    rd_of(AGCC_OFF_COMMAND) |=> cfg_rdata[8] == $past(bus_master_enable_bit) &&
      cfg_rdata[2:0] == $past(rate_select) &&
      cfg_rdata[31:24] == $past(programmed_request_depth))
    else $error("command read does not match stored fields");

endmodule // agcc_regs

//--- agcc_sync.sv
`timescale 1ns/1ns
// Two-stage synchroniser for a level from a pin.
module agcc_sync
  import agcc_pkg::*;
(
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule // agcc_sync

//--- agp_capability_config_test.sv
`timescale 1ns/1ns
module agp_capability_config_test;
  import agcc_pkg::*;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic        strap = 1'b0;
  logic        init_req = 1'b0;
  logic [7:0]  cfg_addr;
  logic [3:0]  cfg_be;
  logic        cfg_wr;
  logic        cfg_rd;
  logic [31:0] cfg_wdata;
  logic [31:0] cfg_rdata;
  logic        cfg_rack;
  logic        ok;
  logic        men;
  logic [7:0]  depth;
  logic [2:0]  rate;
  int          n_fail = 0;
  int          checked = 0;
  always #5 ref_clk = ~ref_clk;
  agcc_host agcc_host_i (.ref_clk(ref_clk), .cfg_rdata(cfg_rdata), .cfg_rack(cfg_rack),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_wdata(cfg_wdata));
  agcc_regs agcc_regs_i (.ref_clk(ref_clk), .rst(rst), .cfg_addr(cfg_addr), .cfg_be(cfg_be),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rack(cfg_rack), .agp_strap_pin(strap), .init_req(init_req), .init_req_ok(ok),
    .bus_master_enable_bit(men), .programmed_request_depth(depth), .rate_select(rate));
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] d;
    logic        ack;
    agcc_host_i.rd(a, d, ack);
    chk({what, " ack"}, 32'h1, {31'h0, ack});
    chk(what, exp, d);
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(negedge ref_clk);
    rst = 1'b0;
    rd_chk("capability_list_pointer strap low", 8'h34, 32'h0);
    strap = 1'b1;
    init_req = 1'b1;
    repeat (3) @(negedge ref_clk);
    chk("gate off", 32'h0, {31'h0, ok});
    rd_chk("capability_list_pointer", 8'h34, 32'h44);
    for (int i = 0; i < 2; i++)
    begin
      rd_chk("header", 8'h44, 32'h0010_0002);
      rd_chk("status", 8'h48, 32'h0400_0001);
      rd_chk("command", 8'h4C, i ? 32'hFF00_0107 : 32'h0000_0001);
      agcc_host_i.wr(8'h44, 4'hF, 32'hFFFF_FFFF);
      agcc_host_i.wr(8'h48, 4'hF, 32'hFFFF_FFFF);
      agcc_host_i.wr(8'h4C, 4'hF, 32'hFFFF_FFFF);
    end
    chk("gate on", 32'h1, {31'h0, ok});
    agcc_host_i.wr(8'h4C, 4'h1, 32'h0000_0000);
    rd_chk("command lane", 8'h4C, 32'hFF00_0100);
    chk("rate out", 32'h0, {29'h0, rate});
    agcc_host_i.start_target(8'h04);
    rd_chk("command start", 8'h4C, 32'h0400_0101);
    chk("depth out", 32'h4, {24'h0, depth});
    rd_chk("unmapped", 8'h60, 32'h0);
    @(negedge ref_clk);
    rst = 1'b1;
    #1;
    chk("enable in reset", 32'h0, {31'h0, men});
    chk("rate in reset", 32'h1, {29'h0, rate});
    @(negedge ref_clk);
    rst = 1'b0;
    rd_chk("command after reset", 8'h4C, 32'h0000_0001);
    complete_run();
  end
  initial
  begin
    #5000;
    n_fail++;
    complete_run();
  end
endmodule // agp_capability_config_test
